// ==== shared/adc_serial_pkg.sv ====
package adc_serial_pkg;

  // Timing: conversion length is a longest time, so it rounds down
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_NS = 1600;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;

  // Result code and its saturation limits
  localparam logic [15:0] CODE_MAX = 16'hFFFF;
  localparam logic [15:0] CODE_MIN = 16'h0000;
  localparam logic signed [17:0] LEVEL_MAX = 18'sh0FFFF;

  // Readback framing
  localparam logic START_BIT = 1'b0;
  localparam logic [4:0] BITS_PLAIN = 5'h10;
  localparam logic [4:0] BITS_BUSY = 5'h11;
  localparam logic [8:0] CONV_LAST = 9'(CONV_CYCLES - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CONV = 3'b001,
    ST_PUSH = 3'b010,
    ST_LOAD = 3'b011,
    ST_READ = 3'b100
  } state_e;

  typedef struct packed {
    logic convert_start;
    logic serial_in_select;
    logic serial_clock;
  } pins_s;

  typedef struct packed {
    logic busy_en;
    logic [15:0] code;
  } word_s;

endpackage

// ==== rtl/result_buffer.sv ====
`timescale 1ns/10ps
`default_nettype none

module result_buffer (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // Filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire adc_serial_pkg::word_s i_in_data,
  // Draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output adc_serial_pkg::word_s o_out_data
);

  adc_serial_pkg::word_s mem [2];
  logic wr_ptr;
  logic rd_ptr;
  logic [1:0] count;
  wire push = i_in_valid && o_in_ready;
  wire pop = o_out_valid && i_out_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Flags derive from the count so full and empty never disagree
  assign o_in_ready = (count != 2'h2);
  assign o_out_valid = (count != 2'h0);
  assign o_out_data = mem[rd_ptr];

  // Storage is not reset; only the pointers carry meaning
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
    end else begin
      wr_ptr <= wr_ptr ^ push;
      rd_ptr <= rd_ptr ^ pop;
      count <= count + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

`default_nettype wire

// ==== rtl/adc_serial_port.sv ====
// Operation
// - Convert-start rise latches the select input; mode holds for conversion and readback
// - Select high at that edge gives chip-select mode, low gives chain mode
// - Select tied to convert-start always yields chain mode
// - Optional start bit ahead of the result acts as busy indicator
// - Chip-select mode: busy on if convert-start or select low at conversion end
// - Chain mode: busy on only if serial clock high at convert-start rise
// - Power down automatically at the end of every conversion
// - 3-wire: convert-start starts conversion and frames readback
// - 4-wire: select input frames readback independent of convert-start
// - Chain mode shifts select-input data through the output path
// - Convert-start rise ends acquisition and starts conversion
// - Conversion timed by internal clock, serial clock not needed
// - 16-bit straight binary, saturating at FFFF and 0000
// - 3-wire no busy: release output after 16th falling edge or convert-start rise
`timescale 1ns/10ps
`default_nettype none

module adc_serial_port (
  // Clock and reset
  input wire logic I_SYS_CLK,
  input wire logic I_ARST_N,
  // Serial pins from the host
  input wire logic I_CONVERT_START,
  input wire logic I_SERIAL_IN_SELECT,
  input wire logic I_SERIAL_CLOCK,
  // Held sample from the comparator array, settled before conversion end
  input wire logic signed [17:0] I_ANALOG_LEVEL,
  // Serial output pin, three-state
  output logic O_SERIAL_OUT,
  output logic O_SERIAL_OUT_EN,
  // Status
  output logic O_POWER_DOWN,
  output logic O_CHAIN_MODE
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  adc_serial_pkg::pins_s pins_in;
  adc_serial_pkg::pins_s sync_meta;
  adc_serial_pkg::pins_s sync_q2;
  adc_serial_pkg::pins_s sync_q3;
  adc_serial_pkg::state_e state;
  adc_serial_pkg::state_e next_state;
  adc_serial_pkg::word_s word_in;
  adc_serial_pkg::word_s word_out;
  logic [8:0] conv_cnt;
  logic [15:0] code;
  logic [16:0] shift;
  logic [16:0] next_shift;
  logic [4:0] bits_left;
  logic [4:0] next_bits_left;
  logic chain_mode;
  logic busy_en;
  logic started;
  logic next_out_en;
  logic buf_in_ready;
  logic buf_out_valid;

  // Saturate the held level to a straight binary code
  function automatic logic [15:0] saturate(input logic signed [17:0] level);
    if (level < 0) begin
      return adc_serial_pkg::CODE_MIN;
    end else if (level > adc_serial_pkg::LEVEL_MAX) begin
      return adc_serial_pkg::CODE_MAX;
    end
    return level[15:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; third stage feeds edge detection and the select sample at the convert edge
  assign pins_in = '{I_CONVERT_START, I_SERIAL_IN_SELECT, I_SERIAL_CLOCK};

  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      sync_meta <= '0;
      sync_q2 <= '0;
      sync_q3 <= '0;
    end else begin
      sync_meta <= pins_in;
      sync_q2 <= sync_meta;
      sync_q3 <= sync_q2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decoded events and levels
  wire start_rise = sync_q2.convert_start && !sync_q3.convert_start;
  wire sck_fall = !sync_q2.serial_clock && sync_q3.serial_clock;
  // Select one stage older than the edge models its hold time: tied pins give chain
  wire sel_at_edge = sync_q3.serial_in_select;
  wire chain_in = chain_mode && sync_q2.serial_in_select;
  wire conv_done = (state == adc_serial_pkg::ST_CONV) &&
                   (conv_cnt == adc_serial_pkg::CONV_LAST);
  wire busy_at_end = !sync_q2.convert_start || !sync_q2.serial_in_select;
  // Convert-start low frames 3-wire reads, select low frames 4-wire reads
  wire cs_select = !(sync_q2.convert_start && sync_q2.serial_in_select);
  wire drive_now = chain_mode || cs_select;
  wire read_end = !chain_mode && ((bits_left == 5'h00) || (started && !cs_select));
  wire load_word = (state == adc_serial_pkg::ST_LOAD) && buf_out_valid && !start_rise;

  assign word_in = '{busy_en, code};

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer; a new convert-start rise aborts any readback
  always_comb begin
    next_state = state;
    case (state)
      adc_serial_pkg::ST_IDLE: begin
        if (start_rise) begin
          next_state = adc_serial_pkg::ST_CONV;
        end
      end
      adc_serial_pkg::ST_CONV: begin
        // Runs to completion whatever the pins do
        if (conv_done) begin
          next_state = adc_serial_pkg::ST_PUSH;
        end
      end
      adc_serial_pkg::ST_PUSH: begin
        if (start_rise) begin
          next_state = adc_serial_pkg::ST_CONV;
        end else if (buf_in_ready) begin
          next_state = adc_serial_pkg::ST_LOAD;
        end
      end
      adc_serial_pkg::ST_LOAD: begin
        if (start_rise) begin
          next_state = adc_serial_pkg::ST_CONV;
        end else if (buf_out_valid) begin
          next_state = adc_serial_pkg::ST_READ;
        end
      end
      adc_serial_pkg::ST_READ: begin
        if (start_rise) begin
          next_state = adc_serial_pkg::ST_CONV;
        end else if (read_end) begin
          next_state = adc_serial_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = adc_serial_pkg::ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shift path: MSB first; a plain word feeds in above its pad bit so a chain stays 16 deep
  always_comb begin
    next_shift = shift;
    next_bits_left = bits_left;
    if (load_word) begin
      if (word_out.busy_en) begin
        next_shift = {adc_serial_pkg::START_BIT, word_out.code};
        next_bits_left = adc_serial_pkg::BITS_BUSY;
      end else begin
        next_shift = {word_out.code, 1'b0};
        next_bits_left = adc_serial_pkg::BITS_PLAIN;
      end
    end else if (state == adc_serial_pkg::ST_READ && sck_fall && drive_now) begin
      next_shift = busy_en ? {shift[15:0], chain_in} : {shift[15:1], chain_in, 1'b0};
      next_bits_left = (bits_left == 5'h00) ? 5'h00 : bits_left - 5'h01;
    end
  end

  // Output drives only while reading, and outside chain mode only while framed
  assign next_out_en = (next_state == adc_serial_pkg::ST_READ) && drive_now;

  ////////////////////////////////////////////////////////////////////////////
  // State, mode and busy registers
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state <= adc_serial_pkg::ST_IDLE;
      conv_cnt <= 9'h000;
      chain_mode <= 1'b0;
      busy_en <= 1'b0;
    end else begin
      state <= next_state;
      conv_cnt <= (state == adc_serial_pkg::ST_CONV) ? conv_cnt + 9'h001 : 9'h000;
      if (start_rise && state != adc_serial_pkg::ST_CONV) begin
        chain_mode <= !sel_at_edge;
        busy_en <= !sel_at_edge && sync_q2.serial_clock;
      end else if (conv_done && !chain_mode) begin
        busy_en <= busy_at_end;
      end
    end
  end

  // Result capture at conversion end
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      code <= adc_serial_pkg::CODE_MIN;
    end else if (conv_done) begin
      code <= saturate(I_ANALOG_LEVEL);
    end
  end

  // Readback registers
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      shift <= 17'h00000;
      bits_left <= 5'h00;
      started <= 1'b0;
    end else begin
      shift <= next_shift;
      bits_left <= next_bits_left;
      started <= (state == adc_serial_pkg::ST_READ) && (started || cs_select);
    end
  end

  // Output flops; power down everywhere outside conversion
  always_ff @(posedge I_SYS_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      O_SERIAL_OUT <= 1'b0;
      O_SERIAL_OUT_EN <= 1'b0;
      O_POWER_DOWN <= 1'b1;
      O_CHAIN_MODE <= 1'b0;
    end else begin
      O_SERIAL_OUT <= next_shift[16];
      O_SERIAL_OUT_EN <= next_out_en;
      O_POWER_DOWN <= (next_state != adc_serial_pkg::ST_CONV);
      O_CHAIN_MODE <= chain_mode;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between converter and shifter; a stalled shifter
  // holds the sequencer in its push state rather than dropping a word
  result_buffer u_buffer (
    .i_clk(I_SYS_CLK),
    .i_arst_n(I_ARST_N),
    .i_in_valid(state == adc_serial_pkg::ST_PUSH),
    .o_in_ready(buf_in_ready),
    .i_in_data(word_in),
    .o_out_valid(buf_out_valid),
    .i_out_ready(load_word),
    .o_out_data(word_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_ARST_N);

  a_mode_latch: assert property (
    (start_rise && state != adc_serial_pkg::ST_CONV) |=>
      (chain_mode == !$past(sync_q3.serial_in_select)) ##1 $stable(chain_mode)[*2])
    else $error("mode not latched at convert edge");
  a_cs_select: assert property (
    (start_rise && state != adc_serial_pkg::ST_CONV && sel_at_edge) |=> !chain_mode)
    else $error("select high did not give chip-select mode");
  a_tied_chain: assert property (
    (start_rise && state != adc_serial_pkg::ST_CONV && !sync_q3.serial_in_select)
      |=> chain_mode)
    else $error("select low did not give chain mode");
  a_chain_busy: assert property (
    (start_rise && state != adc_serial_pkg::ST_CONV) |=>
      busy_en == ($past(sync_q2.serial_clock) && chain_mode))
    else $error("chain busy not taken from serial clock");
  a_cs_busy: assert property (
    (conv_done && !chain_mode) |=> busy_en == $past(busy_at_end) ##1 $stable(busy_en))
    else $error("chip-select busy not taken at conversion end");
  a_start_bit: assert property (
    (load_word && word_out.busy_en) |=>
      shift[16] == adc_serial_pkg::START_BIT && bits_left == adc_serial_pkg::BITS_BUSY)
    else $error("start bit missing ahead of result");
  a_conv_start: assert property (
    (start_rise && state != adc_serial_pkg::ST_CONV) |=>
      state == adc_serial_pkg::ST_CONV && conv_cnt == 9'h000)
    else $error("conversion did not start");
  a_conv_length: assert property (
    (state == adc_serial_pkg::ST_CONV) |-> conv_cnt <= adc_serial_pkg::CONV_LAST)
    else $error("conversion overran its length");
  a_power_down: assert property (
    $fell(state == adc_serial_pkg::ST_CONV) |-> O_POWER_DOWN && !$past(O_POWER_DOWN))
    else $error("no power down after conversion");
  a_saturate: assert property (
    (conv_done && I_ANALOG_LEVEL < 0) |=> code == adc_serial_pkg::CODE_MIN)
    else $error("underrange code not saturated");
  a_release_hiz: assert property (
    (state == adc_serial_pkg::ST_READ && !chain_mode && bits_left == 5'h00)
      |=> !O_SERIAL_OUT_EN)
    else $error("output still driven after last bit");
  a_idle_hiz: assert property (
    (state != adc_serial_pkg::ST_READ) |-> !O_SERIAL_OUT_EN)
    else $error("output driven outside readback");
  a_chain_shift: assert property (
    (state == adc_serial_pkg::ST_READ && chain_mode && sck_fall && !start_rise)
      |=> (busy_en ? shift[0] : shift[1]) == $past(sync_q2.serial_in_select))
    else $error("chain data not shifted in");

  c_chain_read: cover property (state == adc_serial_pkg::ST_READ && chain_mode && sck_fall);
  c_cs_busy: cover property (load_word && word_out.busy_en && !chain_mode);
  c_cs_full: cover property (state == adc_serial_pkg::ST_READ && !chain_mode &&
                             bits_left == 5'h00);
  c_abort: cover property (state == adc_serial_pkg::ST_READ && start_rise);

endmodule

`default_nettype wire

// ==== sim/serial_host.sv ====
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////
// Host side of the serial port: drives the pins, samples the data line
module serial_host (
  // Clock
  input wire logic i_clk,
  // Data line from the converter
  input wire logic i_data,
  input wire logic i_data_en,
  // Pins toward the converter
  output logic o_start,
  output logic o_sel,
  output logic o_sck
);
  logic line;
  // Pull-up: a released line reads high, never the last bit driven
  assign line = i_data_en ? i_data : 1'b1;
  // Pins idle before reset ends
  initial begin
    o_start = 1'b0;
    o_sel = 1'b1;
    o_sck = 1'b0;
  end
  // Pins move one fixed delay after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  // Four cycles a step keeps half periods clear of the synchroniser
  task automatic pins(input logic strobe, input logic sel, input logic sck);
    o_start = strobe;
    o_sel = sel;
    o_sck = sck;
    tick(4);
  endtask
  // Mode levels settle first, then the convert rise
  task automatic start(input logic sel, input logic sck);
    pins(1'b0, sel, sck);
    pins(1'b1, sel, sck);
  endtask
  // Sample before each falling edge, MSB first
  task automatic read(input int n, output logic [16:0] v);
    v = '0;
    for (int i = 0; i < n; i++) begin
      v = {v[15:0], line};
      pins(o_start, o_sel, 1'b1);
      pins(o_start, o_sel, 1'b0);
    end
  endtask
endmodule
`default_nettype wire

// ==== sim/adc_serial_mode_select_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////
module adc_serial_mode_select_bench;
  logic clk;
  logic arst_n;
  logic signed [17:0] level;
  logic strobe, sel, sck, out_pin, out_en, pd, chain;
  logic [16:0] v;
  logic [15:0] code;
  logic busy;
  int m;
  int error_cnt = 0;
  int cmp_count = 0;
  logic signed [17:0] lv [4] = '{-18'sd5, 18'sd70000, 18'sd0, 18'sd65535};

  // Free-running system clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  adc_serial_port DUT (.I_SYS_CLK(clk), .I_ARST_N(arst_n), .I_CONVERT_START(strobe),
    .I_SERIAL_IN_SELECT(sel), .I_SERIAL_CLOCK(sck), .I_ANALOG_LEVEL(level),
    .O_SERIAL_OUT(out_pin), .O_SERIAL_OUT_EN(out_en), .O_POWER_DOWN(pd), .O_CHAIN_MODE(chain));
  serial_host host (.i_clk(clk), .i_data(out_pin), .i_data_en(out_en), .o_start(strobe),
    .o_sel(sel), .o_sck(sck));

  ////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string name, input logic [16:0] seen, input logic [16:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Out-of-range levels clamp to the end codes
  function automatic logic [15:0] sat(input logic signed [17:0] l);
    if (l < 0) return adc_serial_pkg::CODE_MIN;
    if (l > adc_serial_pkg::LEVEL_MAX) return adc_serial_pkg::CODE_MAX;
    return l[15:0];
  endfunction
  // Bounded wait for power-down; the serial clock stays still meanwhile
  task automatic wait_conv;
    int n;
    logic in_range;
    n = 0;
    chk("power_down", {16'h0, pd}, 17'h0);
    while (pd !== 1'b1 && n < 1000) begin
      host.tick(1);
      n++;
    end
    if (n >= 1000) begin
      error_cnt++;
      end_sim();
    end
    in_range = n > adc_serial_pkg::CONV_CYCLES - 8 && n < adc_serial_pkg::CONV_CYCLES + 8;
    chk("conv_len", {16'h0, in_range}, 17'h1);
    host.tick(4);
  endtask

  ////////////////////////////////////////////////////////////////
  // Seven pin set-ups in turn, twice; the second pass of set-up 0 (3-wire, no busy) aborts mid-read
  initial begin
    arst_n = 1'b0;
    level = '0;
    void'($urandom(2));
    host.tick(20);
    chk("reset_pd", {16'h0, pd}, 17'h1);
    chk("reset_en", {16'h0, out_en}, 17'h0);
    arst_n = 1'b1;
    host.tick(4);
    for (int i = 0; i < 14; i++) begin
      m = i % 7;
      level = (i < 4) ? lv[i] : 18'(int'($urandom_range(67535)) - 2000);
      code = sat(level);
      busy = (m == 1 || m == 3 || m == 5);
      case (m)
        0, 1, 2, 3: host.start(1'b1, 1'b0);
        4: host.start(1'b0, 1'b0);
        5: host.start(1'b0, 1'b1);
        default: begin
          host.pins(1'b0, 1'b0, 1'b0);
          host.pins(1'b1, 1'b1, 1'b0);
        end
      endcase
      if (m == 1) host.pins(1'b0, 1'b1, 1'b0);
      if (m == 3) host.pins(1'b1, 1'b0, 1'b0);
      if (m == 5) host.pins(1'b1, 1'b0, 1'b0);
      wait_conv();
      chk("chain_mode", {16'h0, chain}, 17'(m >= 4));
      if (m == 0 || m == 2) chk("idle_en", {16'h0, out_en}, 17'h0);
      if (m == 0) host.pins(1'b0, 1'b1, 1'b0);
      if (m == 2) host.pins(1'b1, 1'b0, 1'b0);
      if (m == 4) host.pins(1'b1, 1'b1, 1'b0);
      if (m == 0 && i > 6) begin
        host.read(8, v);
        chk("part_result", v, {9'h0, code[15:8]});
        host.pins(1'b1, 1'b1, 1'b0);
        chk("abort_en", {16'h0, out_en}, 17'h0);
        wait_conv();
      end else begin
        host.read(busy ? 17 : 16, v);
        chk("result", v, busy ? {adc_serial_pkg::START_BIT, code} : {1'b0, code});
      end
      if (m < 4) begin
        if (m == 2) host.pins(1'b1, 1'b1, 1'b0);
        host.tick(4);
        chk("release", {16'h0, out_en}, 17'h0);
      end
      // Chain passes the select input on after its own word
      if (m == 4) begin
        host.pins(1'b1, 1'b1, 1'b0);
        host.read(3, v);
        chk("chain_pass", {14'h0, v[2:0]}, 17'h7);
      end
    end
    end_sim();
  end
endmodule
`default_nettype wire
